// file: pcis_params.svh
// offsets, field positions, reset values and counts of the interrupt steering block
// assumes inclusion by the block only
`ifndef PCIS_PARAMS_SVH
`define PCIS_PARAMS_SVH

// register indices; byte address is four times the index
`define PCIS_IDX_INT_GEN   8'h03
`define PCIS_IDX_CSC       8'h04
`define PCIS_IDX_CFG       8'h05
`define PCIS_IDX_CDGEN     8'h16
`define PCIS_IDX_GLOBAL    8'h1e
`define PCIS_IDX_EVT       8'h40
`define PCIS_IDX_EVMASK    8'h41

// interrupt and general control
`define PCIS_IGC_STEER_LSB 0
`define PCIS_IGC_HOST_INTERRUPT_OUTPUT_EN   4
`define PCIS_IGC_IO_CARD   5
`define PCIS_IGC_RING_EN   7
// card status interrupt configuration
`define PCIS_CFG_SEL_LSB   4
`define PCIS_CFG_CD_EN     3
// card detect and general control
`define PCIS_CDG_GPI_EN    2
`define PCIS_CDG_GPI_FALL  3
`define PCIS_CDG_CD_RESUME 4
// global control
`define PCIS_GLB_LEVEL     1
`define PCIS_GLB_WB        2
`define PCIS_GLB_IRQ14_LVL 3
// card status change flags
`define PCIS_CSC_STS0      0
`define PCIS_CSC_BWARN     1
`define PCIS_CSC_READY     2
`define PCIS_CSC_CD        3
`define PCIS_CSC_GPI       4

// card-side input slots of the synchroniser bank
`define PCIS_IN_CARD_REQUEST_LINE       0
`define PCIS_IN_CD1        1
`define PCIS_IN_CD2        2
`define PCIS_IN_CARD_CHANGE_INPUT     3
`define PCIS_IN_BATTERY_DETECT_FIRST       4
`define PCIS_IN_BATTERY_DETECT_SECOND       5
`define PCIS_IN_READY      6
`define PCIS_IN_GPI        7
`define PCIS_IN_COUNT      8

`define PCIS_REG_RESET     8'h00
`define PCIS_HOST_INTERRUPT_OUTPUT_LOW_CYC  2'h3
`define PCIS_PRIME_CYC     3'h4
`define PCIS_RESP_OKAY     2'h0
`define PCIS_RESP_SLVERR   2'h2

`endif

// file: pcis_pkg.sv
// types shared by the interrupt steering block
// assumes no other file; uses nothing from the parameter header
package pcis_pkg;
   typedef enum logic [0:0] {
      PCIS_MEMORY = 1'b0,
      PCIS_IO     = 1'b1
   } pcis_card_type;
   typedef enum logic [1:0] {
      PCIS_PULSE_IDLE = 2'b00,
      PCIS_PULSE_LOW  = 2'b01,
      PCIS_PULSE_WAIT = 2'b10
   } pcis_pulse_type;
endpackage : pcis_pkg

// file: pcis_steering.sv
// interrupt source collection, steering and waveform shaping for a pc card slot
// assumes one clock aclk, card pins asynchronous, software on axi4-lite
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pcis_params.svh"

module pcis_steering #(
   parameter int ADDR_W = 12
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // card-side pins
   input  wire logic                card_request_line_n,
   input  wire logic                card_detect_first_n,
   input  wire logic                card_detect_second_n,
   input  wire logic                card_change_input_n,
   input  wire logic                battery_detect_first,
   input  wire logic                battery_detect_second,
   input  wire logic                ready_line,
   input  wire logic                general_input_line,
   // host-side interrupt pins
   output var  logic [15:0]         irq_line_out,
   output var  logic [15:0]         irq_line_oe,
   output var  logic                host_interrupt_output_n,
   output var  logic                wake_output_n,
   output var  logic                int_out
);

   if (ADDR_W < 10) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   logic [7:0] igc_r;
   logic [7:0] cfg_r;
   logic [7:0] cdg_r;
   logic [7:0] glb_r;
   logic [4:0] csc_r;
   logic [1:0] evt_r;
   logic [1:0] evmask_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;

   ////////////////////////////////////////////////////////////////////////////
   // card input synchronisers
   logic [`PCIS_IN_COUNT-1:0] pin_raw;
   logic [`PCIS_IN_COUNT-1:0] sync1_r;
   logic [`PCIS_IN_COUNT-1:0] sync2_r;
   logic [`PCIS_IN_COUNT-1:0] sync3_r;
   logic [`PCIS_IN_COUNT-1:0] stable_r;
   logic [`PCIS_IN_COUNT-1:0] rise_r;
   logic [`PCIS_IN_COUNT-1:0] fall_r;
   logic [2:0]                prime_r;

   assign pin_raw = {general_input_line, ready_line, battery_detect_second,
                     battery_detect_first, card_change_input_n, card_detect_second_n,
                     card_detect_first_n, card_request_line_n};

   // a change is taken only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `PCIS_IN_COUNT; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_r[gi]  <= 1'b1;
               sync2_r[gi]  <= 1'b1;
               sync3_r[gi]  <= 1'b1;
               stable_r[gi] <= 1'b1;
               rise_r[gi]   <= 1'b0;
               fall_r[gi]   <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
               rise_r[gi]  <= 1'b0;
               fall_r[gi]  <= 1'b0;
               if (sync2_r[gi] == sync3_r[gi]) begin
                  stable_r[gi] <= sync3_r[gi];
                  // no events until the chain has filled after reset
                  if (prime_r == `PCIS_PRIME_CYC) begin
                     rise_r[gi] <= sync3_r[gi] & ~stable_r[gi];
                     fall_r[gi] <= ~sync3_r[gi] & stable_r[gi];
                  end
               end
            end
         end
      end
   endgenerate

   // stable_r first holds the real pin level one edge after stage three fills,
   // so events open one edge later still; else a low pin fakes a change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prime_r <= 3'h0;
      end else if (prime_r != `PCIS_PRIME_CYC) begin
         prime_r <= prime_r + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source selection and status change flags
   pcis_pkg::pcis_card_type card_type;
   logic [4:0]              csc_set;
   logic [4:0]              csc_clr;
   logic [4:0]              csc_en;
   logic [`PCIS_IN_COUNT-1:0] chg;
   logic                    gpi_evt;
   logic                    stat_pending;
   logic                    card_request_line_active;
   logic                    rd_take;
   logic                    wr_do;
   logic [7:0]              rd_idx;
   logic [7:0]              wr_idx;

   assign chg = rise_r | fall_r;
   assign card_type = pcis_pkg::pcis_card_type'(igc_r[`PCIS_IGC_IO_CARD]);
   assign gpi_evt = cdg_r[`PCIS_CDG_GPI_EN] &
                    (cdg_r[`PCIS_CDG_GPI_FALL] ? fall_r[`PCIS_IN_GPI] : rise_r[`PCIS_IN_GPI]);

   always_comb begin
      csc_set = 5'h00;
      csc_set[`PCIS_CSC_CD]  = chg[`PCIS_IN_CD1] | chg[`PCIS_IN_CD2];
      csc_set[`PCIS_CSC_GPI] = gpi_evt;
      if (card_type == pcis_pkg::PCIS_IO) begin
         csc_set[`PCIS_CSC_STS0] = igc_r[`PCIS_IGC_RING_EN] & fall_r[`PCIS_IN_CARD_CHANGE_INPUT];
      end else begin
         csc_set[`PCIS_CSC_STS0]  = chg[`PCIS_IN_BATTERY_DETECT_FIRST];
         csc_set[`PCIS_CSC_BWARN] = chg[`PCIS_IN_BATTERY_DETECT_SECOND];
         csc_set[`PCIS_CSC_READY] = chg[`PCIS_IN_READY];
      end
   end

   always_comb begin
      csc_clr = 5'h00;
      if (rd_take && rd_idx == `PCIS_IDX_CSC) begin
         csc_clr = 5'h1f;
      end else if (wr_do && wr_idx == `PCIS_IDX_CSC && glb_r[`PCIS_GLB_WB]) begin
         csc_clr = wdata_r[4:0];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csc_r <= 5'h00;
      end else begin
         csc_r <= (csc_r & ~csc_clr) | csc_set;
      end
   end

   assign csc_en = {1'b1, cfg_r[3:0]};
   assign stat_pending = |(csc_r & csc_en);
   // request line low means pending; the card lifts it to cancel
   assign card_request_line_active = (card_type == pcis_pkg::PCIS_IO) & ~stable_r[`PCIS_IN_CARD_REQUEST_LINE];

   ////////////////////////////////////////////////////////////////////////////
   // irq line steering and waveform
   function automatic logic [15:0] pcis_decode(input logic [3:0] code);
      logic [15:0] hot;
      hot = 16'h0000;
      case (code)
         4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: hot[code] = 1'b1;
         default: hot = 16'h0000;
      endcase
      return hot;
   endfunction : pcis_decode

   logic [15:0] card_request_line_sel;
   logic [15:0] stat_sel;
   logic        host_interrupt_output_en;

   assign host_interrupt_output_en  = igc_r[`PCIS_IGC_HOST_INTERRUPT_OUTPUT_EN];
   assign card_request_line_sel = (card_type == pcis_pkg::PCIS_IO) ? pcis_decode(igc_r[3:0]) : 16'h0000;
   assign stat_sel = host_interrupt_output_en ? 16'h0000 : pcis_decode(cfg_r[7:4]);

   generate
      for (gi = 0; gi < 16; gi++) begin : g_irq
         logic sel;
         logic pend;
         logic lvl;
         assign sel  = card_request_line_sel[gi] | stat_sel[gi];
         assign pend = (card_request_line_sel[gi] & card_request_line_active) | (stat_sel[gi] & stat_pending);
         assign lvl  = glb_r[`PCIS_GLB_LEVEL] | ((gi == 14) & glb_r[`PCIS_GLB_IRQ14_LVL]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_line_out[gi] <= 1'b0;
               irq_line_oe[gi]  <= 1'b0;
            end else if (lvl) begin
               irq_line_out[gi] <= 1'b0;
               irq_line_oe[gi]  <= sel & pend;
            end else begin
               irq_line_out[gi] <= pend;
               irq_line_oe[gi]  <= sel;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // host interrupt pulse and wake output
   pcis_pkg::pcis_pulse_type pulse_r;
   logic [1:0]               pulse_cnt_r;
   logic                     stat_pending_d_r;
   logic                     card_request_line_active_d_r;
   logic                     stat_rise;

   assign stat_rise = stat_pending & ~stat_pending_d_r;

   // one pulse per new pending state; a fresh one waits for the flags to clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_r                 <= pcis_pkg::PCIS_PULSE_IDLE;
         pulse_cnt_r             <= 2'h0;
         host_interrupt_output_n <= 1'b1;
      end else begin
         case (pulse_r)
            pcis_pkg::PCIS_PULSE_IDLE: begin
               if (stat_rise && host_interrupt_output_en) begin
                  pulse_r                 <= pcis_pkg::PCIS_PULSE_LOW;
                  pulse_cnt_r             <= `PCIS_HOST_INTERRUPT_OUTPUT_LOW_CYC - 2'h1;
                  host_interrupt_output_n <= 1'b0;
               end
            end
            pcis_pkg::PCIS_PULSE_LOW: begin
               if (pulse_cnt_r == 2'h0) begin
                  pulse_r                 <= pcis_pkg::PCIS_PULSE_WAIT;
                  host_interrupt_output_n <= 1'b1;
               end
               pulse_cnt_r <= pulse_cnt_r - 2'h1;
            end
            pcis_pkg::PCIS_PULSE_WAIT: begin
               if (!stat_pending) begin
                  pulse_r <= pcis_pkg::PCIS_PULSE_IDLE;
               end
            end
            default: begin
               pulse_r                 <= pcis_pkg::PCIS_PULSE_IDLE;
               host_interrupt_output_n <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_output_n <= 1'b1;
      end else begin
         wake_output_n <= ~(csc_r[`PCIS_CSC_CD] & cdg_r[`PCIS_CDG_CD_RESUME] &
                            cfg_r[`PCIS_CFG_CD_EN]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system interrupt: sticky events, mask, level output
   logic [1:0] evt_set;
   logic [1:0] evt_clr;
   logic [1:0] evt_nxt;

   assign evt_set = {card_request_line_active & ~card_request_line_active_d_r, stat_rise};
   assign evt_clr = (wr_do && wr_idx == `PCIS_IDX_EVT && wstrb_r[0]) ? wdata_r[1:0] : 2'h0;
   assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_pending_d_r <= 1'b0;
         card_request_line_active_d_r  <= 1'b0;
         evt_r            <= 2'h0;
         int_out          <= 1'b0;
      end else begin
         stat_pending_d_r <= stat_pending;
         card_request_line_active_d_r  <= card_request_line_active;
         evt_r            <= evt_nxt;
         int_out          <= |(evt_nxt & evmask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic              aw_hold_r;
   logic              w_hold_r;
   logic [7:0]        waddr_idx_r;
   logic              aw_take;
   logic              w_take;
   logic              wr_hit;

   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take  = s_axi_wvalid & s_axi_wready;
   assign wr_do   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   assign wr_idx  = waddr_idx_r;
   assign rd_take = s_axi_arvalid & s_axi_arready;
   assign rd_idx  = s_axi_araddr[9:2];

   always_comb begin
      case (wr_idx)
         `PCIS_IDX_INT_GEN, `PCIS_IDX_CSC, `PCIS_IDX_CFG, `PCIS_IDX_CDGEN,
         `PCIS_IDX_GLOBAL, `PCIS_IDX_EVT, `PCIS_IDX_EVMASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         waddr_idx_r   <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PCIS_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_r   <= 1'b1;
            waddr_idx_r <= s_axi_awaddr[9:2];
         end else if (wr_do) begin
            aw_hold_r <= 1'b0;
         end
         if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (wr_do) begin
            w_hold_r <= 1'b0;
         end
         s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_bvalid;
         s_axi_wready  <= ~w_hold_r & ~w_take & ~s_axi_bvalid;
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PCIS_RESP_OKAY : `PCIS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // byte lane zero carries every 8-bit register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         igc_r    <= `PCIS_REG_RESET;
         cfg_r    <= `PCIS_REG_RESET;
         cdg_r    <= `PCIS_REG_RESET;
         glb_r    <= `PCIS_REG_RESET;
         evmask_r <= 2'h0;
      end else if (wr_do && wstrb_r[0]) begin
         case (wr_idx)
            `PCIS_IDX_INT_GEN: igc_r    <= wdata_r[7:0];
            `PCIS_IDX_CFG:     cfg_r    <= wdata_r[7:0];
            `PCIS_IDX_CDGEN:   cdg_r    <= wdata_r[7:0];
            `PCIS_IDX_GLOBAL:  glb_r    <= wdata_r[7:0];
            `PCIS_IDX_EVMASK:  evmask_r <= wdata_r[1:0];
            default:           evmask_r <= evmask_r;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PCIS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PCIS_RESP_OKAY;
            case (rd_idx)
               `PCIS_IDX_INT_GEN: s_axi_rdata <= {24'h000000, igc_r};
               `PCIS_IDX_CSC:     s_axi_rdata <= {27'h0000000, csc_r};
               `PCIS_IDX_CFG:     s_axi_rdata <= {24'h000000, cfg_r};
               `PCIS_IDX_CDGEN:   s_axi_rdata <= {24'h000000, cdg_r};
               `PCIS_IDX_GLOBAL:  s_axi_rdata <= {24'h000000, glb_r};
               `PCIS_IDX_EVT:     s_axi_rdata <= {30'h00000000, evt_r};
               `PCIS_IDX_EVMASK:  s_axi_rdata <= {30'h00000000, evmask_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `PCIS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_host_interrupt_output_pulse;
      @(posedge aclk) disable iff (!aresetn)
      $fell(host_interrupt_output_n) |-> !host_interrupt_output_n [*3] ##1 host_interrupt_output_n;
   endproperty
   a_host_interrupt_output_pulse: assert property (p_host_interrupt_output_pulse) else $error("host pulse not three cycles");

   property p_host_interrupt_output_start;
      @(posedge aclk) disable iff (!aresetn)
      (stat_rise && host_interrupt_output_en && pulse_r == pcis_pkg::PCIS_PULSE_IDLE) |=> !host_interrupt_output_n;
   endproperty
   a_host_interrupt_output_start: assert property (p_host_interrupt_output_start) else $error("host pulse did not start");

   property p_wake;
      @(posedge aclk) disable iff (!aresetn)
      (csc_r[`PCIS_CSC_CD] && cdg_r[`PCIS_CDG_CD_RESUME] && cfg_r[`PCIS_CFG_CD_EN])
         |=> !wake_output_n;
   endproperty
   a_wake: assert property (p_wake) else $error("wake output not driven");

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
      (csc_set[`PCIS_CSC_CD] && csc_clr[`PCIS_CSC_CD]) |=> csc_r[`PCIS_CSC_CD];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag set lost to clear");

   property p_read_clears;
      @(posedge aclk) disable iff (!aresetn)
      (rd_take && rd_idx == `PCIS_IDX_CSC && csc_set == 5'h00) |=> csc_r == 5'h00;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

   property p_unselected_hiz;
      @(posedge aclk) disable iff (!aresetn)
      (igc_r[3:0] == 4'h0 && (cfg_r[7:4] == 4'h0 || host_interrupt_output_en)) [*2] |-> irq_line_oe == 16'h0000;
   endproperty
   a_unselected_hiz: assert property (p_unselected_hiz) else $error("unselected line driven");

   property p_level_low;
      @(posedge aclk) disable iff (!aresetn)
      (glb_r[`PCIS_GLB_LEVEL] && stat_pending && stat_sel[5] && !card_request_line_sel[5])
         |=> (irq_line_oe[5] && !irq_line_out[5]);
   endproperty
   a_level_low: assert property (p_level_low) else $error("level mode line not low");

   property p_edge_high;
      @(posedge aclk) disable iff (!aresetn)
      (!glb_r[`PCIS_GLB_LEVEL] && stat_sel[3] && !card_request_line_sel[3])
         |=> (irq_line_oe[3] && irq_line_out[3] == $past(stat_pending));
   endproperty
   a_edge_high: assert property (p_edge_high) else $error("edge mode line wrong");

   property p_irq14_level;
      @(posedge aclk) disable iff (!aresetn)
      (glb_r[`PCIS_GLB_IRQ14_LVL] && !(card_request_line_sel[14] || stat_sel[14])) |=> !irq_line_oe[14];
   endproperty
   a_irq14_level: assert property (p_irq14_level) else $error("irq14 driven while idle");

   property p_mem_no_request;
      @(posedge aclk) disable iff (!aresetn)
      (card_type == pcis_pkg::PCIS_MEMORY) |-> !card_request_line_active && card_request_line_sel == 16'h0000;
   endproperty
   a_mem_no_request: assert property (p_mem_no_request) else $error("request on memory card");

endmodule : pcis_steering

`default_nettype wire

// file: pcis_isa_host.sv
// isa host side model: irq pin resolution and host interrupt pulse width
// assumes the steering block's pin ports and one clock aclk
`timescale 1ns/1ns
`default_nettype none
module pcis_isa_host (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [15:0] irq_line_out,
   input  wire logic [15:0] irq_line_oe,
   input  wire logic        host_interrupt_output_n,
   output var  logic [15:0] irq_wire,
   output var  logic [3:0]  low_len
);
   logic [3:0] run_r;
   // undriven irq pins float to the board pull-up
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         irq_wire[i] = irq_line_oe[i] ? irq_line_out[i] : 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////
   // width of the last completed low pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_r   <= 4'h0;
         low_len <= 4'h0;
      end else if (!host_interrupt_output_n) begin
         run_r <= run_r + 4'h1;
      end else if (run_r != 4'h0) begin
         low_len <= run_r;
         run_r   <= 4'h0;
      end
   end
endmodule : pcis_isa_host
`default_nettype wire

// file: pc_card_interrupt_steering_bench.sv
// self-checking bench: axi4-lite tasks, card pin stimulus, irq checks
// assumes the steering block and the isa host model in this folder
`timescale 1ns/1ns
`default_nettype none
module pc_card_interrupt_steering_bench;
   logic aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, low_len;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic card_request_line_n = 1, card_detect_first_n = 0, card_detect_second_n = 0;
   logic card_change_input_n = 1, battery_detect_first = 0, battery_detect_second = 0;
   logic ready_line = 0, general_input_line = 0;
   logic [15:0] irq_line_out, irq_line_oe, irq_wire, ex;
   logic host_interrupt_output_n, wake_output_n, int_out;
   logic [31:0] d;
   int err_count = 0, checks = 0;
   pcis_steering dut (.*);
   pcis_isa_host host (.*);
   always #10 aclk = ~aclk;
   ////////////////////////////////////////////////////////////
   task stop_test;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   // write waits for bvalid; each channel drops once its ready is seen
   task wr(input logic [11:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid && n < 40);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
      if (n >= 40) begin err_count++; stop_test(); end
   endtask : wr
   task rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid && n < 40);
      d = s_axi_rdata; rs = s_axi_rresp;
      s_axi_rready <= 0;
      if (n >= 40) begin err_count++; stop_test(); end
   endtask : rd
   ////////////////////////////////////////////////////////////
   initial begin
      cyc(2);
      aresetn <= 1;
      cyc(4);
      rd(12'h00c); chk(d, 0);
      rd(12'h008); chk(d, 0); chk(rs, 2);
      wr(12'h008, 8'h55); chk(rs, 2);
      // request pending on an io card, every steering code in edge mode
      wr(12'h00c, 8'h20);
      card_request_line_n <= 0;
      cyc(8);
      for (int c = 0; c < 16; c++) begin
         wr(12'h00c, 8'h20 | c[7:0]);
         cyc(2);
         ex = (c inside {3, 4, 5, 7, 9, 10, 11, 12, 14, 15}) ? 16'h1 << c : 16'h0;
         chk(irq_line_oe, ex);
         chk(irq_line_out, ex);
      end
      wr(12'h078, 8'h02); cyc(2);
      chk(irq_line_oe, 16'h8000);
      chk(irq_wire, 16'h7fff);
      wr(12'h00c, 8'h0f); cyc(2); chk(irq_line_oe, 0);
      wr(12'h00c, 8'h2e); wr(12'h078, 8'h08); cyc(2);
      chk({irq_line_oe, irq_line_out}, 32'h40000000);
      card_request_line_n <= 1;
      cyc(8); chk(irq_line_oe, 0);
      // status change via card detect, irq5, write-back clear
      wr(12'h078, 8'h04); wr(12'h014, 8'h58);
      card_detect_first_n <= 1;
      cyc(8); chk(irq_line_out, 16'h0020);
      wr(12'h010, 8'h08); cyc(2); chk(irq_line_out, 0);
      wr(12'h078, 8'h00);
      card_detect_first_n <= 0;
      cyc(8);
      wr(12'h010, 8'h08); cyc(2); chk(irq_line_out, 16'h0020);
      rd(12'h010); chk(d, 8'h08);
      cyc(2); chk(irq_line_out, 0);
      // host interrupt output and event status interrupt
      wr(12'h00c, 8'h30); wr(12'h100, 8'h03); wr(12'h104, 8'h01);
      cyc(2); chk(int_out, 0);
      card_detect_second_n <= 1;
      cyc(12); chk(low_len, 3);
      chk({irq_line_out, int_out}, 1);
      wr(12'h100, 8'h01); cyc(2); chk(int_out, 0);
      rd(12'h010);
      wr(12'h058, 8'h10);
      card_detect_second_n <= 0;
      cyc(8); chk(wake_output_n, 0);
      rd(12'h010);
      // ring input on an io card
      wr(12'h00c, 8'ha0);
      card_change_input_n <= 0;
      cyc(8); rd(12'h010); chk(d[0], 1);
      // memory card sources plus rising gpi
      wr(12'h00c, 8'h00); wr(12'h058, 8'h04);
      battery_detect_first <= 1; battery_detect_second <= 1;
      ready_line <= 1; general_input_line <= 1;
      cyc(8); rd(12'h010); chk(d, 8'h17);
      // falling gpi edge only when the falling select is set
      wr(12'h058, 8'h0c); general_input_line <= 0;
      cyc(8); rd(12'h010); chk(d, 8'h10);
      stop_test();
   end
endmodule : pc_card_interrupt_steering_bench
`default_nettype wire
